// file: tdcp_consts.vh
// Purpose: Constants for the event word packer (offsets, fields, resets, codes)
// Assumes: Included by its bare name from the packer module
// Notes: Definitions only
`ifndef TDCP_CONSTS_VH
`define TDCP_CONSTS_VH

// Register byte offsets
`define TDCP_ADDR_CTRL 8'h00
`define TDCP_ADDR_STATUS 8'h04
`define TDCP_ADDR_INT_STAT 8'h08
`define TDCP_ADDR_INT_EN 8'h0C
`define TDCP_ADDR_INT_CLR 8'h10
`define TDCP_ADDR_REC_CNT 8'h14

// Control fields and reset value
`define TDCP_CTRL_EN_BIT 0
`define TDCP_CTRL_FMT_LSB 8
`define TDCP_CTRL_FMT_MSB 12
`define TDCP_CTRL_RST 32'h00001C00

// Interrupt status bits
`define TDCP_INT_REC_DONE 0
`define TDCP_INT_LOST 1
`define TDCP_INT_RST 2'h0

// Format selector values
`define TDCP_FMT_1C 5'h1C
`define TDCP_FMT_18 5'h18
`define TDCP_FMT_15 5'h15
`define TDCP_FMT_11 5'h11
`define TDCP_FMT_0D 5'h0D
`define TDCP_FMT_09 5'h09
`define TDCP_FMT_05 5'h05
`define TDCP_FMT_01 5'h01

// Channel codes
`define TDCP_CODE_START 4'h6
`define TDCP_CODE_STOP_BASE 4'h8

// Byte index of the last byte of a record
`define TDCP_LAST_SHORT 3'h3
`define TDCP_LAST_LONG 3'h7

// Bus responses
`define TDCP_RESP_OKAY 2'h0
`define TDCP_RESP_SLVERR 2'h2

`endif

// file: tdcp_event_word_packer.v
// Purpose: Packs timestamped hits into list-mode records and streams them out
// Assumes: Hits, sweep starts and overflow come from logic on aclk
// Notes: Registers reached over AXI4-Lite, one write and one read at a time
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tdcp_consts.vh"

module tdcp_event_word_packer (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Timing events
  input wire sweep_start,
  input wire fifo_overflow,
  // Hit input
  input wire hit_valid,
  input wire [2:0] hit_chan,
  input wire hit_falling,
  input wire [15:0] hit_tag,
  output reg hit_ready,
  // Record byte stream
  output reg [7:0] out_byte,
  output reg out_valid,
  output reg out_last,
  input wire out_ready,
  // Interrupt
  output reg irq
);

  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;

  // Byte-lane merge of a write into a register
  function [31:0] tdcp_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      tdcp_merge = old_val;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          tdcp_merge[8*i +: 8] = new_val[8*i +: 8];
    end
  endfunction

  // Known selector values only
  function tdcp_fmt_ok;
    input [4:0] fmt;
    begin
      case (fmt)
        `TDCP_FMT_1C, `TDCP_FMT_18, `TDCP_FMT_15, `TDCP_FMT_11,
        `TDCP_FMT_0D, `TDCP_FMT_09, `TDCP_FMT_05, `TDCP_FMT_01:
          tdcp_fmt_ok = 1'b1;
        default:
          tdcp_fmt_ok = 1'b0;
      endcase
    end
  endfunction

  // Field layout of one record
  function [63:0] tdcp_pack;
    input [4:0] fmt;
    input [3:0] code;
    input edge_dn;
    input [52:0] t;
    input [25:0] sw;
    input [15:0] tag;
    input lost;
    reg [63:0] r;
    begin
      r = 64'h0;
      r[3:0] = code;
      r[4] = edge_dn;
      case (fmt)
        `TDCP_FMT_18: // Only 26 time bits fit between the edge bit and the lost flag
          r[31:5] = {lost, t[25:0]};
        `TDCP_FMT_15:
          r[63:5] = {lost, tag, sw[25:0], t[15:0]};
        `TDCP_FMT_11:
          r[63:5] = {lost, tag, sw[19:0], t[21:0]};
        `TDCP_FMT_0D:
          r[63:5] = {lost, tag[7:0], sw[19:0], t[29:0]};
        `TDCP_FMT_09:
          r[63:5] = {lost, sw[19:0], t[37:0]};
        `TDCP_FMT_05:
          r[63:5] = {lost, tag, t[41:0]};
        `TDCP_FMT_01:
          r[63:5] = {lost, tag[4:0], t[52:0]};
        default:
          r[31:5] = {lost, sw[9:0], t[15:0]};
      endcase
      tdcp_pack = r;
    end
  endfunction

  // Register state
  reg [31:0] ctrl_ff;
  reg [1:0] int_stat_ff;
  reg [1:0] int_en_ff;
  reg [31:0] rec_cnt_ff;
  reg aw_hold_ff;
  reg [7:0] awaddr_ff;
  reg w_hold_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  // Packer state
  reg [1:0] state_ff;
  reg [63:0] rec_ff;
  reg [2:0] bidx_ff;
  reg [2:0] last_idx_ff;
  reg [52:0] time_ff;
  reg [25:0] sweep_ff;
  reg lost_ff;

  wire ctrl_en = ctrl_ff[`TDCP_CTRL_EN_BIT];
  wire [4:0] ctrl_fmt = ctrl_ff[`TDCP_CTRL_FMT_MSB:`TDCP_CTRL_FMT_LSB];

  // Write channel
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_wr = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
  wire nxt_aw_hold = aw_take | (aw_hold_ff & ~do_wr);
  wire nxt_w_hold = w_take | (w_hold_ff & ~do_wr);
  wire nxt_bvalid = do_wr | (s_axi_bvalid & ~s_axi_bready);
  wire wr_ctrl = do_wr & ({awaddr_ff[7:2], 2'h0} == `TDCP_ADDR_CTRL);
  wire wr_int_en = do_wr & ({awaddr_ff[7:2], 2'h0} == `TDCP_ADDR_INT_EN);
  wire wr_int_clr = do_wr & ({awaddr_ff[7:2], 2'h0} == `TDCP_ADDR_INT_CLR);
  wire [31:0] ctrl_merged = tdcp_merge(ctrl_ff, wdata_ff, wstrb_ff);
  wire [31:0] int_en_merged = tdcp_merge({30'h0, int_en_ff}, wdata_ff, wstrb_ff);

  // Read channel
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire nxt_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

  // Packer handshakes
  wire load = hit_valid & hit_ready;
  wire beat = out_valid & out_ready;
  wire at_last = (bidx_ff == last_idx_ff);
  wire [2:0] nxt_bidx = bidx_ff + 3'h1;
  wire drop = hit_valid & ~hit_ready & ctrl_en;
  wire lost_now = lost_ff | fifo_overflow | drop;
  wire [3:0] hit_code = (hit_chan == 3'h0) ? `TDCP_CODE_START :
                        (`TDCP_CODE_STOP_BASE + {1'b0, hit_chan});
  wire [63:0] rec_word = tdcp_pack(ctrl_fmt, hit_code, hit_falling, time_ff,
                                   sweep_ff, hit_tag, lost_now);
  wire rec_done = beat & at_last;
  wire [1:0] int_set = {fifo_overflow | drop, rec_done};
  wire [1:0] int_clr = wr_int_clr & wstrb_ff[0] ? wdata_ff[1:0] : 2'h0;

  reg [1:0] nxt_state;

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (load)
          nxt_state = ST_SEND;
      ST_SEND:
        if (rec_done)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // AXI write path
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TDCP_RESP_OKAY;
    end
    else
    begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      if (aw_take)
        awaddr_ff <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      // Ready stays low while a write is held or answered
      s_axi_awready <= ~nxt_aw_hold & ~nxt_bvalid;
      s_axi_wready <= ~nxt_w_hold & ~nxt_bvalid;
      s_axi_bvalid <= nxt_bvalid;
      if (do_wr)
        s_axi_bresp <= (wr_ctrl | wr_int_en | wr_int_clr) ?
                       `TDCP_RESP_OKAY : `TDCP_RESP_SLVERR;
    end
  end

  // Control registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff <= `TDCP_CTRL_RST;
      int_en_ff <= `TDCP_INT_RST;
      int_stat_ff <= `TDCP_INT_RST;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_ff[`TDCP_CTRL_EN_BIT] <= ctrl_merged[`TDCP_CTRL_EN_BIT];
        // Unknown selectors are ignored so a record is never half defined
        if (tdcp_fmt_ok(ctrl_merged[`TDCP_CTRL_FMT_MSB:`TDCP_CTRL_FMT_LSB]))
          ctrl_ff[`TDCP_CTRL_FMT_MSB:`TDCP_CTRL_FMT_LSB] <=
            ctrl_merged[`TDCP_CTRL_FMT_MSB:`TDCP_CTRL_FMT_LSB];
      end
      if (wr_int_en)
        int_en_ff <= int_en_merged[1:0];
      // Set wins over clear
      int_stat_ff <= (int_stat_ff & ~int_clr) | int_set;
      irq <= |(((int_stat_ff & ~int_clr) | int_set) & int_en_ff);
    end
  end

  // AXI read path
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TDCP_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~nxt_rvalid;
      s_axi_rvalid <= nxt_rvalid;
      if (ar_take)
      begin
        s_axi_rresp <= `TDCP_RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'h0})
          `TDCP_ADDR_CTRL: s_axi_rdata <= ctrl_ff;
          `TDCP_ADDR_STATUS: s_axi_rdata <= {29'h0, hit_ready, lost_ff, state_ff[1]};
          `TDCP_ADDR_INT_STAT: s_axi_rdata <= {30'h0, int_stat_ff};
          `TDCP_ADDR_INT_EN: s_axi_rdata <= {30'h0, int_en_ff};
          `TDCP_ADDR_INT_CLR: s_axi_rdata <= 32'h00000000;
          `TDCP_ADDR_REC_CNT: s_axi_rdata <= rec_cnt_ff;
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TDCP_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Sweep timebase, one bin per clock
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      time_ff <= 53'h0;
      sweep_ff <= 26'h0;
    end
    else if (sweep_start)
    begin
      time_ff <= 53'h0;
      sweep_ff <= sweep_ff + 26'h1;
    end
    else
      time_ff <= time_ff + 53'h1;
  end

  // Lost flag held until stamped into the next record
  always @(posedge aclk)
  begin
    if (!aresetn)
      lost_ff <= 1'b0;
    else if (load)
      lost_ff <= 1'b0;
    else if (fifo_overflow | drop)
      lost_ff <= 1'b1;
  end

  // Record serializer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ST_IDLE;
      rec_ff <= 64'h0;
      bidx_ff <= 3'h0;
      last_idx_ff <= `TDCP_LAST_SHORT;
      out_byte <= 8'h00;
      out_valid <= 1'b0;
      out_last <= 1'b0;
      hit_ready <= 1'b0;
      rec_cnt_ff <= 32'h00000000;
    end
    else
    begin
      state_ff <= nxt_state;
      // One record in flight: new hits wait for the stream to drain
      hit_ready <= (nxt_state == ST_IDLE) & ctrl_en;
      if (load)
      begin
        rec_ff <= rec_word;
        bidx_ff <= 3'h0;
        last_idx_ff <= ((ctrl_fmt == `TDCP_FMT_1C) || (ctrl_fmt == `TDCP_FMT_18)) ?
                       `TDCP_LAST_SHORT : `TDCP_LAST_LONG;
        out_byte <= rec_word[7:0];
        out_valid <= 1'b1;
        out_last <= 1'b0;
      end
      else if (beat)
      begin
        if (at_last)
        begin
          out_valid <= 1'b0;
          out_last <= 1'b0;
          rec_cnt_ff <= rec_cnt_ff + 32'h1;
        end
        else
        begin
          bidx_ff <= nxt_bidx;
          out_byte <= rec_ff[8*nxt_bidx +: 8];
          out_last <= (nxt_bidx == last_idx_ff);
        end
      end
    end
  end

endmodule // tdcp_event_word_packer

`default_nettype wire

// file: tdcp_packer_properties.sv
// Purpose: Concurrent checks on the packer hit and byte stream ports
// Assumes: Bound to the packer top, single clock domain
// Notes: Time bits are judged by the bench, framing and flags here
`timescale 1ns/1ps
`default_nettype none
module tdcp_packer_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Hit side
  input wire logic hit_valid,
  input wire logic [2:0] hit_chan,
  input wire logic hit_falling,
  input wire logic fifo_overflow,
  input wire logic hit_ready,
  // Stream side
  input wire logic [7:0] out_byte,
  input wire logic out_valid,
  input wire logic out_last,
  input wire logic out_ready
);
  logic [2:0] cnt_ff, ch_ff;
  logic fall_ff, lost_ff;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Byte index and fields of the record in flight
  always @(posedge aclk)
    if (!aresetn)
    begin
      cnt_ff <= 3'h0;
      ch_ff <= 3'h0;
      fall_ff <= 1'b0;
      lost_ff <= 1'b0;
    end
    else
    begin
      if (out_valid && out_ready)
        cnt_ff <= out_last ? 3'h0 : cnt_ff + 3'h1;
      if (hit_valid && hit_ready)
      begin
        ch_ff <= hit_chan;
        fall_ff <= hit_falling;
        lost_ff <= fifo_overflow;
      end
    end
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_byte) && $stable(out_last);
  endproperty
  a_hold: assert property (p_hold) else $error("byte moved before taken");
  property p_answer;
    hit_valid && hit_ready |=> out_valid && cnt_ff == 3'h0;
  endproperty
  a_answer: assert property (p_answer) else $error("no byte after take");
  property p_busy;
    out_valid |-> !hit_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("hit open mid record");
  property p_len;
    out_valid && out_last |-> cnt_ff == 3'h3 || cnt_ff == 3'h7;
  endproperty
  a_len: assert property (p_len) else $error("bad record length");
  property p_len8;
    out_valid && cnt_ff == 3'h7 |-> out_last;
  endproperty
  a_len8: assert property (p_len8) else $error("long record overruns");
  property p_code;
    out_valid && cnt_ff == 3'h0 |-> out_byte[3:0] == (ch_ff == 3'h0 ? 4'h6 : {1'b1, ch_ff});
  endproperty
  a_code: assert property (p_code) else $error("bad channel code");
  property p_edge;
    out_valid && cnt_ff == 3'h0 |-> out_byte[4] == fall_ff;
  endproperty
  a_edge: assert property (p_edge) else $error("bad edge bit");
  property p_lost;
    out_valid && out_last && lost_ff |-> out_byte[7];
  endproperty
  a_lost: assert property (p_lost) else $error("lost flag missing");
endmodule // tdcp_packer_props
bind tdcp_event_word_packer tdcp_packer_props u_props (.aclk, .aresetn, .hit_valid, .hit_chan,
  .hit_falling, .fifo_overflow, .hit_ready, .out_byte, .out_valid, .out_last, .out_ready);
`default_nettype wire

// file: tdcp_host.sv
// Purpose: Host reader that gathers stream bytes into records
// Assumes: Ready is a level, toggled each cycle when slow
// Notes: Records and byte counts queue up for the bench
`timescale 1ns/1ps
`default_nettype none
module tdcp_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pace select, high for a stalling reader
  input wire logic slow,
  // Record byte stream
  input wire logic [7:0] out_byte,
  input wire logic out_valid,
  input wire logic out_last,
  output logic out_ready
);
  logic [63:0] recs[$];
  int lens[$];
  logic [63:0] acc;
  int n;
  always @(posedge aclk)
    if (!aresetn)
    begin
      out_ready <= 1'b0;
      acc = 64'h0;
      n = 0;
    end
    else
    begin
      out_ready <= slow ? !out_ready : 1'b1;
      if (out_valid && out_ready)
      begin
        acc[8*n +: 8] = out_byte;
        n++;
        if (out_last)
        begin
          recs.push_back(acc);
          lens.push_back(n);
          acc = 64'h0;
          n = 0;
        end
      end
    end
endmodule // tdcp_host
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the event word packer
// Assumes: Host model drains the stream, stalling on formats 18, 11, 09 and 01
// Notes: Time judged as the spacing of two hits in one sweep
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk, aresetn, awv, wv, bre, arv, rre, sws, ovf, hv, hfall, slow;
  logic [7:0] awa, ara;
  logic [31:0] wd;
  logic [2:0] hch;
  logic [15:0] htag;
  wire logic awr, wrdy, bv, arr, rv, hrdy, ov, ol, ordy, irq;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdat;
  wire logic [7:0] ob;
  int err_count, n_checks, sw_n, cyc;
  logic [4:0] fmt [8] = '{5'h1C, 5'h18, 5'h15, 5'h11, 5'h0D, 5'h09, 5'h05, 5'h01};
  int tw [8] = '{16, 26, 16, 22, 30, 38, 42, 53};
  int sw [8] = '{10, 0, 26, 20, 20, 20, 0, 0};
  int gw [8] = '{0, 0, 16, 16, 8, 0, 16, 5};
  tdcp_event_word_packer u_dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .sweep_start(sws),
    .fifo_overflow(ovf), .hit_valid(hv), .hit_chan(hch), .hit_falling(hfall),
    .hit_tag(htag), .hit_ready(hrdy), .out_byte(ob), .out_valid(ov), .out_last(ol),
    .out_ready(ordy), .irq);
  tdcp_host u_host (.aclk, .aresetn, .slow, .out_byte(ob), .out_valid(ov), .out_last(ol),
    .out_ready(ordy));
  initial
  begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  task chk(input logic [63:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task end_of_test;
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tw_;
    ta = 0;
    tw_ = 0;
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    while (!(ta && tw_))
    begin
      @(posedge aclk);
      ta |= awr;
      tw_ |= wrdy;
      awv <= !ta;
      wv <= !tw_;
    end
    // Bready left high so back to back writes never drive it twice in one step
    do @(posedge aclk); while (!bv);
    chk(br, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    ara <= a;
    arv <= 1;
    rre <= 1;
    do @(posedge aclk); while (!arr);
    arv <= 0;
    do @(posedge aclk); while (!rv);
    chk(rr, e);
    if (e == 2'h0)
      chk(rdat, d);
  endtask
  // Raise a hit only once ready, unless a refusal is wanted
  task hit(input logic [2:0] c, input logic f, input logic [15:0] g, input logic w, output int t);
    @(posedge aclk);
    while (w && !hrdy) @(posedge aclk);
    hch <= c;
    hfall <= f;
    htag <= g;
    hv <= 1;
    do @(posedge aclk); while (!hrdy);
    t = cyc;
    hv <= 0;
  endtask
  function automatic logic [63:0] ex(int i, logic [2:0] c, logic f, logic [15:0] g, logic l);
    logic [63:0] m;
    m = {60'h0, c == 3'h0 ? 4'h6 : {1'b1, c}} | (64'(f) << 4);
    m |= (64'(sw_n) & ((64'h1 << sw[i]) - 1)) << (5 + tw[i]);
    m |= (64'(g) & ((64'h1 << gw[i]) - 1)) << (5 + tw[i] + sw[i]);
    return m | (64'(l) << (i < 2 ? 31 : 63));
  endfunction
  task get(input int i, input logic [2:0] c, input logic f, input logic [15:0] g,
    input logic l, output logic [63:0] t);
    logic [63:0] r, tm;
    while (u_host.recs.size() == 0) @(posedge aclk);
    r = u_host.recs.pop_front();
    tm = ((64'h1 << tw[i]) - 1) << 5;
    chk(u_host.lens.pop_front(), i < 2 ? 4 : 8);
    chk(r & ~tm, ex(i, c, f, g, l));
    t = (r & tm) >> 5;
  endtask
  task regs;
    rd(8'h00, 32'h00001C00, 2'h0);
    rd(8'h0C, 32'h0, 2'h0);
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h04, 32'h1, 2'h2);
    wr(8'h0C, 32'h3, 2'h0);
    rd(8'h0C, 32'h3, 2'h0);
  endtask
  task fmts(input int i);
    int a, b;
    logic [63:0] ta, tb_, m;
    slow <= i[0];
    wr(8'h00, {19'h0, fmt[i], 8'h01}, 2'h0);
    sws <= 1;
    sw_n++;
    @(posedge aclk);
    sws <= 0;
    hit(i[2:0], i[0], 16'hA5C3 + 16'(i), 1, a);
    hit(~i[2:0], !i[0], 16'h5A3C, 1, b);
    get(i, i[2:0], i[0], 16'hA5C3 + 16'(i), 0, ta);
    get(i, ~i[2:0], !i[0], 16'h5A3C, 0, tb_);
    m = (64'h1 << tw[i]) - 1;
    chk((tb_ - ta) & m, 64'(b - a) & m);
  endtask
  // Refused hit and overflow both flag loss; only loss is unmasked
  task lost;
    int a;
    logic [63:0] t;
    wr(8'h0C, 32'h2, 2'h0);
    wr(8'h10, 32'h3, 2'h0);
    repeat (3) @(posedge aclk);
    chk(irq, 0);
    hit(3'h1, 0, 16'h0001, 1, a);
    hit(3'h2, 1, 16'h0002, 0, a);
    hit(3'h3, 0, 16'h0003, 1, a);
    get(7, 3'h1, 0, 16'h0001, 0, t);
    get(7, 3'h2, 1, 16'h0002, 1, t);
    get(7, 3'h3, 0, 16'h0003, 0, t);
    chk(irq, 1);
    rd(8'h08, 32'h3, 2'h0);
    rd(8'h14, 32'h00000013, 2'h0);
    wr(8'h10, 32'h2, 2'h0);
    repeat (3) @(posedge aclk);
    chk(irq, 0);
    ovf <= 1;
    hit(3'h4, 1, 16'h0004, 1, a);
    ovf <= 0;
    get(7, 3'h4, 1, 16'h0004, 1, t);
    chk(irq, 1);
    rd(8'h04, 32'h00000004, 2'h0);
  endtask
  initial
  begin
    {awv, wv, bre, arv, rre, sws, ovf, hv, hfall, slow} = 0;
    {awa, ara, wd, hch, htag} = 0;
    {err_count, n_checks, sw_n, cyc} = 0;
    aresetn = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    regs();
    for (int i = 0; i < 8; i++)
      fmts(i);
    lost();
    end_of_test();
  end
  initial
  begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule // tb
`default_nettype wire
